// [test/pwmaux_ctrl_test.sv]
// Self-checking bench for the five-generator PWM auxiliary control block.
// Assumes the constants header is on the include path; bench drives all ports itself.
`include "pwmaux_regs.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD t=%0t got %h exp %h", $time, got, exp); end end

module pwm_aux_blank_chop_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 0, resetn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, chop_clk_gen = 0;
  logic [3:0]  reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, w;
  logic [4:0]  pwm_raw_high = 0, pwm_raw_low = 0, cur_limit_in = 0, fault_in = 0;
  logic [4:0]  gen_high_output, gen_low_output, cur_limit_out, fault_out, fine_period_on, fine_duty_on;
  logic        obs = 0, rd_d = 0, obs_d = 0;
  int          seed = 18650, miscompares = 0, compares = 0;
  logic [15:0] aux_m [5], leb_m [5];
  logic [15:0] rd_q [$];
  logic [29:0] out_q [$];
  logic [15:0] rd_e;
  logic [29:0] out_e;

  pwmaux_ctrl pwmaux_ctrl_inst (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwm_raw_high(pwm_raw_high), .pwm_raw_low(pwm_raw_low), .chop_clk_gen(chop_clk_gen),
    .cur_limit_in(cur_limit_in), .fault_in(fault_in), .gen_high_output(gen_high_output),
    .gen_low_output(gen_low_output), .cur_limit_out(cur_limit_out), .fault_out(fault_out),
    .fine_period_on(fine_period_on), .fine_duty_on(fine_duty_on));

  // Clock generator
  always #5 clk_sys = ~clk_sys;

  // Expected register contents
  function automatic logic [15:0] reg_exp(input logic [3:0] a);
    logic [15:0] s;
    s = 16'h0000;
    for (int g = 0; g < 5; g++) begin
      s[10 + g] = aux_m[g][11:8] > 5;
      s[g] = aux_m[g][5:2] > 5;
    end
    return (a < 5) ? aux_m[a] : (a < 10) ? leb_m[a - 5] : (a == 10) ? s : 16'h0000;
  endfunction

  // Expected outputs from held inputs and model registers
  function automatic logic [29:0] out_exp(input logic [4:0] h, l, lim, flt, input logic cg);
    logic [4:0] gh, gl, lo, fo, fp, fd;
    logic       chop, blank, mask;
    int         cs, bs;
    for (int g = 0; g < 5; g++) begin
      cs = aux_m[g][5:2];
      bs = aux_m[g][11:8];
      chop = (cs == 0) ? cg : (cs <= 5) ? h[cs - 1] : 1'b0;
      blank = (bs >= 1 && bs <= 5) ? h[bs - 1] : 1'b0;
      mask = blank & ((leb_m[g][1] & h[g]) | (leb_m[g][0] & ~h[g]));
      gh[g] = h[g] & (chop | ~aux_m[g][1]);
      gl[g] = l[g] & (chop | ~aux_m[g][0]);
      lo[g] = lim[g] & ~mask;
      fo[g] = flt[g] & ~mask;
      fp[g] = ~aux_m[g][15];
      fd[g] = ~aux_m[g][14];
    end
    return {gh, gl, lo, fo, fp, fd};
  endfunction

  // Register write, model updated with the writable mask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_rd, obs, reg_addr, reg_wdata} <= {3'b100, a, d};
    if (a < 5) aux_m[a] = d & `PWMAUX_AUX_WMASK;
    else if (a < 10) leb_m[a - 5] = d & `PWMAUX_LEB_WMASK;
  endtask

  // Register read, expectation queued
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    {reg_wr, reg_rd, obs, reg_addr} <= {3'b010, a};
    rd_q.push_back(reg_exp(a));
  endtask

  // Random pin stimulus, expectation queued
  task automatic stim();
    logic [20:0] r;
    r = $random(seed);
    @(posedge clk_sys);
    {reg_wr, reg_rd, obs} <= 3'b001;
    {pwm_raw_high, pwm_raw_low, cur_limit_in, fault_in, chop_clk_gen} <= r;
    out_q.push_back(out_exp(r[20:16], r[15:11], r[10:6], r[5:1], r[0]));
  endtask

  // Result watcher
  always @(posedge clk_sys) begin
    rd_d <= reg_rd & resetn;
    obs_d <= obs;
    if (rd_d) begin
      rd_e = rd_q.pop_front();
      `CHK(reg_rdata, rd_e)
    end
    if (obs_d) begin
      out_e = out_q.pop_front();
      `CHK({gen_high_output, gen_low_output, cur_limit_out, fault_out, fine_period_on, fine_duty_on}, out_e)
    end
  end

  task automatic final_report();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #100us;
    miscompares++;
    final_report();
  end

  // Main sequence: reset values, then random programming with selectors 0..9
  initial begin
    for (int g = 0; g < 5; g++) begin
      aux_m[g] = 0;
      leb_m[g] = 0;
    end
    repeat (6) @(posedge clk_sys);
    resetn <= 1;
    for (int a = 0; a < 16; a++) rd(a);
    repeat (3) stim();
    repeat (40) begin
      for (int g = 0; g < 5; g++) begin
        w = $random(seed);
        w[11:8] = {$random(seed)} % 10;
        w[5:2] = {$random(seed)} % 10;
        wr(g, w);
      end
      for (int g = 0; g < 5; g++) wr(5 + g, $random(seed));
      wr(4'hf, $random(seed));
      for (int a = 0; a < 11; a++) rd(a);
      rd(4'hf);
      repeat (8) stim();
    end
    @(posedge clk_sys);
    obs <= 0;
    repeat (3) @(posedge clk_sys);
    final_report();
  end
endmodule // pwm_aux_blank_chop_control_test

// [verilog/pwmaux_ctrl.sv]
// Auxiliary control for five PWM generators: fine resolution disables, state blanking, chopping.
// Assumes raw PWM, limit and fault inputs and the chop clock come from logic on clk_sys.
`include "pwmaux_regs.svh"

// Register index map
// 0x0..0x4  auxiliary control of generators 1..5
//   bit 15 fine period off, bit 14 fine duty off
//   bits 11..8 blank source, bits 5..2 chop source
//   bit 1 high side chop enable, bit 0 low side chop enable
// 0x5..0x9  blank enables of generators 1..5
//   bit 1 blank in high state, bit 0 blank in low state
// 0xa       status, read only
//   bits 14..10 reserved blank code, bits 4..0 reserved chop code
// Other indices read zero and ignore writes
// Chopped outputs stay low while a reserved chop code is set

module pwmaux_ctrl (
  input  wire logic                         clk_sys,
  input  wire logic                         resetn,
  input  wire logic                         clk_en,
  input  wire logic [`PWMAUX_ADDR_W-1:0]    reg_addr,
  input  wire logic [15:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [15:0]                  reg_rdata,
  input  wire logic [`PWMAUX_NUM_GEN-1:0]   pwm_raw_high,
  input  wire logic [`PWMAUX_NUM_GEN-1:0]   pwm_raw_low,
  input  wire logic                         chop_clk_gen,
  input  wire logic [`PWMAUX_NUM_GEN-1:0]   cur_limit_in,
  input  wire logic [`PWMAUX_NUM_GEN-1:0]   fault_in,
  output logic      [`PWMAUX_NUM_GEN-1:0]   gen_high_output,
  output logic      [`PWMAUX_NUM_GEN-1:0]   gen_low_output,
  output logic      [`PWMAUX_NUM_GEN-1:0]   cur_limit_out,
  output logic      [`PWMAUX_NUM_GEN-1:0]   fault_out,
  output logic      [`PWMAUX_NUM_GEN-1:0]   fine_period_on,
  output logic      [`PWMAUX_NUM_GEN-1:0]   fine_duty_on
);

  pwmaux_pkg::pwmaux_word_t aux_q [`PWMAUX_NUM_GEN];
  pwmaux_pkg::pwmaux_word_t leb_q [`PWMAUX_NUM_GEN];
  logic [`PWMAUX_NUM_GEN-1:0] blank_sig;
  logic [`PWMAUX_NUM_GEN-1:0] chop_sig;
  logic [`PWMAUX_NUM_GEN-1:0] hi_d;
  logic [`PWMAUX_NUM_GEN-1:0] lo_d;
  logic [`PWMAUX_NUM_GEN-1:0] lim_d;
  logic [`PWMAUX_NUM_GEN-1:0] flt_d;
  logic [`PWMAUX_NUM_GEN-1:0] blank_err_q;
  logic [`PWMAUX_NUM_GEN-1:0] chop_err_q;

  // One control copy per generator
  genvar g;
  generate
    for (g = 0; g < `PWMAUX_NUM_GEN; g++) begin : gen_ch
      pwmaux_pkg::pwmaux_sel_t bsel;
      pwmaux_pkg::pwmaux_sel_t csel;
      logic                    blank_act;
      assign bsel = aux_q[g][`PWMAUX_BLANK_HI:`PWMAUX_BLANK_LO];
      assign csel = aux_q[g][`PWMAUX_CHOP_HI:`PWMAUX_CHOP_LO];

      // Register writes; unimplemented bits masked off
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          aux_q[g] <= `PWMAUX_AUX_RESET;
          leb_q[g] <= `PWMAUX_LEB_RESET;
        end else if (clk_en && reg_wr) begin
          if (reg_addr == `PWMAUX_OFF_AUX1 + 4'(g)) begin
            aux_q[g] <= reg_wdata & `PWMAUX_AUX_WMASK;
          end
          if (reg_addr == `PWMAUX_OFF_LEB1 + 4'(g)) begin
            leb_q[g] <= reg_wdata & `PWMAUX_LEB_WMASK;
          end
        end
      end

      // Blank source decode; zero and reserved codes give no blanking
      always_comb begin
        blank_sig[g] = 1'b0;
        if (bsel != `PWMAUX_SRC_NONE && bsel <= `PWMAUX_SRC_LAST) begin
          blank_sig[g] = pwm_raw_high[3'(bsel - 4'h1)];
        end
      end

      // Chop source decode; zero picks the chop clock generator
      always_comb begin
        chop_sig[g] = 1'b0;
        if (csel == `PWMAUX_SRC_NONE) begin
          chop_sig[g] = chop_clk_gen;
        end else if (csel <= `PWMAUX_SRC_LAST) begin
          chop_sig[g] = pwm_raw_high[3'(csel - 4'h1)];
        end
      end

      // Blanking active in the high or low PWM state when enabled for it
      assign blank_act = blank_sig[g] &&
                         ((pwm_raw_high[g] && leb_q[g][`PWMAUX_BIT_BLANK_HST]) ||
                          (!pwm_raw_high[g] && leb_q[g][`PWMAUX_BIT_BLANK_LST]));
      assign lim_d[g] = cur_limit_in[g] && !blank_act;
      assign flt_d[g] = fault_in[g] && !blank_act;

      // Chop gating of both outputs
      assign hi_d[g] = aux_q[g][`PWMAUX_BIT_CHOP_H] ? (pwm_raw_high[g] & chop_sig[g])
                                                    : pwm_raw_high[g];
      assign lo_d[g] = aux_q[g][`PWMAUX_BIT_CHOP_L] ? (pwm_raw_low[g] & chop_sig[g])
                                                    : pwm_raw_low[g];

      // Reserved selector codes flagged for status
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          blank_err_q[g] <= 1'b0;
          chop_err_q[g]  <= 1'b0;
        end else if (clk_en) begin
          blank_err_q[g] <= bsel > `PWMAUX_SRC_LAST;
          chop_err_q[g]  <= csel > `PWMAUX_SRC_LAST;
        end
      end

      // Registered output stage
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          gen_high_output[g] <= 1'b0;
          gen_low_output[g]  <= 1'b0;
          cur_limit_out[g]   <= 1'b0;
          fault_out[g]       <= 1'b0;
          fine_period_on[g]  <= 1'b1;
          fine_duty_on[g]    <= 1'b1;
        end else if (clk_en) begin
          gen_high_output[g] <= hi_d[g];
          gen_low_output[g]  <= lo_d[g];
          cur_limit_out[g]   <= lim_d[g];
          fault_out[g]       <= flt_d[g];
          fine_period_on[g]  <= !aux_q[g][`PWMAUX_BIT_FINE_PER];
          fine_duty_on[g]    <= !aux_q[g][`PWMAUX_BIT_FINE_DUTY];
        end
      end

      // Chopped high output follows PWM and chop one cycle later
      chk_chop_high_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && aux_q[g][`PWMAUX_BIT_CHOP_H] && !chop_sig[g] && $past(clk_en) ##1 clk_en |-> !gen_high_output[g])
        else $error("high output active while chop low");
      chk_chop_low_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && aux_q[g][`PWMAUX_BIT_CHOP_L] && pwm_raw_low[g] && chop_sig[g] |=> gen_low_output[g] || !clk_en)
        else $error("low output lost while both high");
      chk_pass_high: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && !aux_q[g][`PWMAUX_BIT_CHOP_H] |=> !$past(clk_en) || gen_high_output[g] == $past(pwm_raw_high[g]))
        else $error("unchopped high output differs");
      chk_blank_none: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && bsel == `PWMAUX_SRC_NONE && fault_in[g] |=> fault_out[g] || !$past(clk_en))
        else $error("fault masked with no blank source");
      chk_blank_mask: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && blank_sig[g] && pwm_raw_high[g] && leb_q[g][`PWMAUX_BIT_BLANK_HST] |=> !cur_limit_out[g] && !fault_out[g])
        else $error("limit not blanked in high state");
      chk_blank_gated: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && leb_q[g][1:0] == 2'b00 && cur_limit_in[g] |=> cur_limit_out[g])
        else $error("limit masked without blank enable");
      chk_fine_period: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en ##1 clk_en |-> fine_period_on[g] != $past(aux_q[g][`PWMAUX_BIT_FINE_PER]))
        else $error("fine period enable wrong");
      chk_fine_duty: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en ##1 clk_en |-> fine_duty_on[g] != $past(aux_q[g][`PWMAUX_BIT_FINE_DUTY]))
        else $error("fine duty enable wrong");
      chk_chop_internal: assert property (@(posedge clk_sys) disable iff (!resetn)
        csel == `PWMAUX_SRC_NONE |-> chop_sig[g] == chop_clk_gen)
        else $error("internal chop clock not selected");
      chk_src_decode: assert property (@(posedge clk_sys) disable iff (!resetn)
        csel == 4'h3 && bsel == 4'h5 |-> chop_sig[g] == pwm_raw_high[2] && blank_sig[g] == pwm_raw_high[4])
        else $error("source decode wrong");
      chk_unimpl_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (aux_q[g] & ~`PWMAUX_AUX_WMASK) == 16'h0000)
        else $error("unimplemented bits set");

      // Chop gate: chopped output only while both PWM and chop signal are high; unchopped low output follows PWM
      chk_chop_high_and: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && aux_q[g][`PWMAUX_BIT_CHOP_H]
        |=> gen_high_output[g] == ($past(pwm_raw_high[g]) && $past(chop_sig[g])))
        else $error("chopped high output wrong");
      chk_chop_low_and: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && aux_q[g][`PWMAUX_BIT_CHOP_L]
        |=> gen_low_output[g] == ($past(pwm_raw_low[g]) && $past(chop_sig[g])))
        else $error("chopped low output wrong");
      chk_chop_low_off: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && aux_q[g][`PWMAUX_BIT_CHOP_L] && !chop_sig[g]
        |=> !gen_low_output[g])
        else $error("low output active while chop low");
      chk_pass_low: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && !aux_q[g][`PWMAUX_BIT_CHOP_L]
        |=> gen_low_output[g] == $past(pwm_raw_low[g]))
        else $error("unchopped low output differs");
      chk_chop_high_on: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && aux_q[g][`PWMAUX_BIT_CHOP_H] && chop_sig[g] && pwm_raw_high[g]
        |=> gen_high_output[g])
        else $error("high output lost while both high");

      // Blanking only in the enabled PWM state
      chk_blank_low_state: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && blank_sig[g] && !pwm_raw_high[g] && leb_q[g][`PWMAUX_BIT_BLANK_LST]
        |=> !cur_limit_out[g] && !fault_out[g])
        else $error("inputs not blanked in low state");
      chk_blank_hst_off: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && pwm_raw_high[g] && !leb_q[g][`PWMAUX_BIT_BLANK_HST] && cur_limit_in[g]
        |=> cur_limit_out[g])
        else $error("limit blanked in high state without enable");
      chk_blank_lst_off: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && !pwm_raw_high[g] && !leb_q[g][`PWMAUX_BIT_BLANK_LST] && fault_in[g]
        |=> fault_out[g])
        else $error("fault blanked in low state without enable");

      // Masking can only remove an input, never create one
      chk_limit_no_src: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && !cur_limit_in[g]
        |=> !cur_limit_out[g])
        else $error("limit output without input");
      chk_fault_no_src: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && !fault_in[g]
        |=> !fault_out[g])
        else $error("fault output without input");
      chk_fault_unblanked: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && !blank_sig[g] && fault_in[g]
        |=> fault_out[g])
        else $error("fault masked with blank signal low");

      // Source decodes, end points and reserved codes
      chk_blank_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        bsel == `PWMAUX_SRC_NONE
        |-> !blank_sig[g])
        else $error("blank signal with source zero");
      chk_blank_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
        bsel > `PWMAUX_SRC_LAST
        |-> !blank_sig[g])
        else $error("blank signal from reserved code");
      chk_blank_first: assert property (@(posedge clk_sys) disable iff (!resetn)
        bsel == 4'h1
        |-> blank_sig[g] == pwm_raw_high[0])
        else $error("blank source one wrong");
      chk_chop_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
        csel > `PWMAUX_SRC_LAST
        |-> !chop_sig[g])
        else $error("chop signal from reserved code");
      chk_chop_first: assert property (@(posedge clk_sys) disable iff (!resetn)
        csel == 4'h1
        |-> chop_sig[g] == pwm_raw_high[0])
        else $error("chop source one wrong");
      chk_chop_fifth: assert property (@(posedge clk_sys) disable iff (!resetn)
        csel == 4'h5
        |-> chop_sig[g] == pwm_raw_high[4])
        else $error("chop source five wrong");

      // Reset state and register access of this copy
      chk_reset_state: assert property (@(posedge clk_sys)
        !resetn
        |=> aux_q[g] == `PWMAUX_AUX_RESET && fine_period_on[g] && fine_duty_on[g])
        else $error("reset state wrong");
      chk_aux_readback: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && reg_rd && reg_addr == `PWMAUX_OFF_AUX1 + 4'(g)
        |=> reg_rdata == $past(aux_q[g]))
        else $error("auxiliary read data wrong");
      chk_write_lands: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == `PWMAUX_OFF_AUX1 + 4'(g)
        |=> aux_q[g] == ($past(reg_wdata) & `PWMAUX_AUX_WMASK))
        else $error("auxiliary write wrong");
    end
  endgenerate

  // Read data one cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        for (int i = 0; i < `PWMAUX_NUM_GEN; i++) begin
          if (reg_addr == `PWMAUX_OFF_AUX1 + 4'(i)) begin
            reg_rdata <= aux_q[i];
          end
          if (reg_addr == `PWMAUX_OFF_LEB1 + 4'(i)) begin
            reg_rdata <= leb_q[i];
          end
        end
        if (reg_addr == `PWMAUX_OFF_STAT) begin
          reg_rdata <= {1'b0, blank_err_q, 5'h00, chop_err_q};
        end
      end
    end
  end

  // Read data stands one cycle only; unmapped indices read zero
  chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && !reg_rd
    |=> reg_rdata == 16'h0000)
    else $error("read data without read strobe");
  chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && reg_rd && reg_addr > `PWMAUX_OFF_STAT
    |=> reg_rdata == 16'h0000)
    else $error("unmapped index reads nonzero");

endmodule // pwmaux_ctrl

// [verilog/pwmaux_pkg.sv]
// Types shared by the PWM auxiliary control block.
// Assumes the constants header is included by the design file.
package pwmaux_pkg;
  typedef logic [15:0] pwmaux_word_t;
  typedef logic [3:0]  pwmaux_sel_t;
endpackage : pwmaux_pkg

// [verilog/pwmaux_regs.svh]
// Register offsets, field positions and reset values of the PWM auxiliary control block.
// Assumes a 16-bit register port with two register indices per generator.
`ifndef PWMAUX_REGS_SVH
`define PWMAUX_REGS_SVH

`define PWMAUX_NUM_GEN        5
`define PWMAUX_ADDR_W         4
`define PWMAUX_OFF_AUX1       4'h0
`define PWMAUX_OFF_LEB1       4'h5
`define PWMAUX_OFF_STAT       4'ha
`define PWMAUX_BIT_FINE_PER   15
`define PWMAUX_BIT_FINE_DUTY  14
`define PWMAUX_BLANK_HI       11
`define PWMAUX_BLANK_LO       8
`define PWMAUX_CHOP_HI        5
`define PWMAUX_CHOP_LO        2
`define PWMAUX_BIT_CHOP_H     1
`define PWMAUX_BIT_CHOP_L     0
`define PWMAUX_AUX_WMASK      16'hcf3f
`define PWMAUX_LEB_WMASK      16'h0003
`define PWMAUX_BIT_BLANK_HST  1
`define PWMAUX_BIT_BLANK_LST  0
`define PWMAUX_AUX_RESET      16'h0000
`define PWMAUX_LEB_RESET      16'h0000
`define PWMAUX_SRC_NONE       4'h0
`define PWMAUX_SRC_LAST       4'h5

`endif
